/* shared/irq_upper_pkg.sv */
// Constants shared by the upper-bank interrupt controller files.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package irq_upper_pkg;
  localparam int line_count = 48;
  localparam int bank_lo = 32;
  localparam int bank_width = 16;
  localparam logic [7:0] vector_base = 8'h10;
  localparam logic [7:0] vector_top = 8'h3f;
  // Register byte addresses.
  localparam logic [7:0] off_vector = 8'h00;
  localparam logic [7:0] off_enable_upper = 8'h04;
  localparam logic [7:0] off_status_upper = 8'h08;
  localparam logic [7:0] off_enable_low = 8'h0c;
  localparam logic [7:0] off_enable_mid = 8'h10;
  localparam logic [7:0] off_status_low = 8'h14;
  localparam logic [7:0] off_status_mid = 8'h18;
  localparam logic [7:0] off_nest_depth = 8'h1c;
  localparam logic [15:0] enable_reset = 16'hffff;
  // Line assignment.
  localparam int line_timer0 = 47;
  localparam int line_dma0 = 39;
  localparam int line_dma3 = 36;
  localparam int line_bus0 = 35;
  localparam int line_audio = 34;
  localparam int line_uart_rx = 33;
  localparam int line_transcoder = 32;
  localparam int line_adc = 13;
  localparam int line_wake0 = 12;
  localparam int line_wake7 = 5;
  localparam int line_rng = 3;
  localparam int line_flash = 1;
  // Lines wired to no source: 0, 2, 4, 14, 40..46.
  localparam logic [47:0] unconnected_lines = 48'h7f00_0000_4015;
  localparam int depth_width = 8;
endpackage

/* core/irq_priority_encoder.sv */
// Fixed linear priority encoder over the request lines.
// Assumes the caller has already gated requests with their enables.
`timescale 1ns/100ps
module irq_priority_encoder
  import irq_upper_pkg::*;
#(
  parameter int lines = line_count
)
(
  // Gated requests
  input wire logic [lines-1:0] req,
  // Result
  output logic any,
  output logic [7:0] vector
);
  initial
  begin
    if (lines < 1 || lines > 48)
    begin
      $error("lines out of range");
    end
  end

  always_comb
  begin
    any = 1'b0;
    vector = vector_base;
    for (int i = 0; i < lines; i++)
    begin
      if (req[i])
      begin
        any = 1'b1;
        vector = vector_base + 8'(i); // see [R5]
      end
    end
  end
endmodule

/* core/irq_nest_tracker.sv */
// Handler nesting tracker: counts active handlers, tracks the global gate.
// Assumes entry and exit pulses come from the processor one cycle each.
`timescale 1ns/100ps
module irq_nest_tracker
  import irq_upper_pkg::*;
#(
  parameter int width = depth_width
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Processor events
  input wire logic maskable_entry,
  input wire logic nmi_entry,
  input wire logic handler_exit,
  input wire logic set_global_permit,
  // State
  output logic permit_ff,
  output logic [width-1:0] depth_ff
);
  initial
  begin
    if (width < 2)
    begin
      $error("width too small");
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      permit_ff <= 1'b1;
    end
    else if (maskable_entry)
    begin
      permit_ff <= 1'b0; // see [R9]
    end
    else if (set_global_permit)
    begin
      permit_ff <= 1'b1; // see [R9]
    end
  end

  // Depth saturates instead of refusing, so nesting has no hard limit.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      depth_ff <= '0;
    end
    else if ((maskable_entry || nmi_entry) && !handler_exit)
    begin
      if (depth_ff != '1)
      begin
        depth_ff <= depth_ff + 1'b1; // see [R11]
      end
    end
    else if (handler_exit && !(maskable_entry || nmi_entry) && depth_ff != '0)
    begin
      depth_ff <= depth_ff - 1'b1;
    end
  end
endmodule

/* core/irq_upper_ctrl.sv */
// Upper-bank maskable interrupt controller with vector and nesting logic.
// Assumes peripherals drive level requests synchronous to mclk.
//
// Operation
// [R1] Upper enable mask is 16-bit read/write and resets to all ones.
// [R2] Mask bit n gates request line n; zero blocks, one allows.
// [R3] Upper status is read-only live request view, ignoring the mask.
// [R4] Status bits 47..32 map to lines 47..32; one while requesting.
// [R5] Among enabled pending requests, the highest line number wins.
// [R6] Timer 0, DMA 0..3, bus, audio, transcoder wired to upper lines.
// [R7] Converter, wake-up, random, flash on lower lines; others unconnected. Code wires uart_tx_req to line 15 and mid_req to lines 31..16.
// [R8] Non-maskable requests may always preempt, even another NMI handler.
// [R9] Maskable entry blocks maskables until the handler sets the permit.
// [R10] Enable masks still gate requests while nesting is permitted.
// [R11] Nesting depth has no hardware limit beyond stack memory.
// [R12] Vector register reads highest active enabled line, 10h to 3Fh.
// [R13] Acknowledge read returns a vector held stable through the cycle.
// [R14] Request to the processor asserts while any line is active and enabled.
`timescale 1ns/100ps
module irq_upper_ctrl
  import irq_upper_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Upper sources
  input wire logic timer0_req,
  input wire logic [3:0] dma_req,
  input wire logic bus0_req,
  input wire logic audio_req,
  input wire logic uart_rx_req,
  input wire logic transcoder_req,
  // Lower and middle sources
  input wire logic adc_req,
  input wire logic [7:0] wakeup_req,
  input wire logic rng_req,
  input wire logic flash_req,
  input wire logic [15:0] mid_req,
  input wire logic uart_tx_req,
  // Processor side
  input wire logic inta,
  input wire logic nmi_req,
  input wire logic handler_exit,
  input wire logic set_global_permit,
  output logic irq_out,
  output logic nmi_out,
  output logic [7:0] ack_vector_ff
);
  logic [line_count-1:0] lines;
  logic [line_count-1:0] gated;
  logic [15:0] enable_upper_ff;
  logic [15:0] enable_low_ff;
  logic [15:0] enable_mid_ff;
  logic [31:0] dat_o_ff;
  logic ack_ff;
  logic err_ff;
  logic [7:0] vector_ff;
  logic [7:0] enc_vector;
  logic enc_any;
  logic inta_d_ff;
  logic permit_ff;
  logic [depth_width-1:0] depth_ff;
  logic maskable_entry;
  logic nmi_entry;
  logic bus_req;
  logic mapped;
  logic [31:0] nxt_dat;
  logic inta_rise;
  logic wr_commit;
  logic wr_upper;
  logic wr_low;
  logic wr_mid;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  initial
  begin
    if (bank_lo + bank_width != line_count)
    begin
      $error("upper bank does not end at the top line");
    end
    if (int'(vector_top) - int'(vector_base) != line_count - 1)
    begin
      $error("vector range does not match the line count");
    end
    if (line_timer0 >= line_count || line_transcoder < bank_lo)
    begin
      $error("upper sources fall outside the upper bank");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request lines.

  always_comb
  begin
    lines = '0;
    lines[line_timer0] = timer0_req; // see [R6]
    for (int i = 0; i < 4; i++)
    begin
      lines[line_dma0 - i] = dma_req[i]; // see [R6]
    end
    lines[line_bus0] = bus0_req; // see [R6]
    lines[line_audio] = audio_req; // see [R6]
    lines[line_uart_rx] = uart_rx_req;
    lines[line_transcoder] = transcoder_req; // see [R6]
    lines[31:16] = mid_req;
    lines[15] = uart_tx_req;
    lines[line_adc] = adc_req; // see [R7]
    for (int i = 0; i < 8; i++)
    begin
      lines[line_wake0 - i] = wakeup_req[i]; // see [R7]
    end
    lines[line_rng] = rng_req; // see [R7]
    lines[line_flash] = flash_req; // see [R7]
    lines = lines & ~unconnected_lines; // see [R7]
  end

  // Masks keep gating at every nesting level.
  assign gated = lines & {enable_upper_ff, enable_mid_ff, enable_low_ff}; // see [R2] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Priority and vector.

  irq_priority_encoder #(
    .lines(line_count)
  ) u_enc (
    .req(gated),
    .any(enc_any),
    .vector(enc_vector)
  );

  // The live vector freezes while an acknowledge cycle is in progress.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      vector_ff <= vector_base;
    end
    else if (!inta)
    begin
      vector_ff <= enc_vector; // see [R12] [R13]
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      inta_d_ff <= 1'b0;
    end
    else
    begin
      inta_d_ff <= inta;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ack_vector_ff <= vector_base;
    end
    else if (inta_rise)
    begin
      ack_vector_ff <= vector_ff; // see [R13]
    end
  end

  assign inta_rise = inta && !inta_d_ff;
  assign maskable_entry = inta_rise; // see [R9]
  assign nmi_entry = nmi_req;
  assign irq_out = enc_any && permit_ff; // see [R14] [R9]
  assign nmi_out = nmi_req; // see [R8]

  ////////////////////////////////////////////////////////////////////////////
  // Nesting.

  irq_nest_tracker #(
    .width(depth_width)
  ) u_nest (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .maskable_entry(maskable_entry),
    .nmi_entry(nmi_entry),
    .handler_exit(handler_exit),
    .set_global_permit(set_global_permit),
    .permit_ff(permit_ff),
    .depth_ff(depth_ff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  assign bus_req = cyc_i && stb_i && !ack_ff && !err_ff;
  // Writes land on the edge at which the master samples ack, while it still holds the request.
  assign wr_commit = cyc_i && stb_i && we_i && ack_ff;
  assign wr_upper = wr_commit && (adr_i == off_enable_upper);
  assign wr_low = wr_commit && (adr_i == off_enable_low);
  assign wr_mid = wr_commit && (adr_i == off_enable_mid);

  // Every register offset answers with ack, anything else with err.
  always_comb
  begin
    case (adr_i)
      off_vector, off_enable_upper, off_status_upper, off_enable_low,
      off_enable_mid, off_status_low, off_status_mid, off_nest_depth:
      begin
        mapped = 1'b1;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    nxt_dat = '0;
    case (adr_i)
      off_vector: nxt_dat[7:0] = vector_ff; // see [R12]
      off_enable_upper: nxt_dat[15:0] = enable_upper_ff; // see [R1]
      off_status_upper: nxt_dat[15:0] = lines[47:32]; // see [R3] [R4]
      off_enable_low: nxt_dat[15:0] = enable_low_ff;
      off_enable_mid: nxt_dat[15:0] = enable_mid_ff;
      off_status_low: nxt_dat[15:0] = lines[15:0];
      off_status_mid: nxt_dat[15:0] = lines[31:16];
      off_nest_depth: nxt_dat[depth_width-1:0] = depth_ff;
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= bus_req && mapped;
    end
  end

  // Unmapped offsets are refused and never written.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      err_ff <= 1'b0;
    end
    else
    begin
      err_ff <= bus_req && !mapped;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dat_o_ff <= '0;
    end
    else if (bus_req && !we_i)
    begin
      dat_o_ff <= nxt_dat;
    end
  end

  assign ack_o = ack_ff;
  assign err_o = err_ff;
  assign dat_o = dat_o_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enable_upper_ff <= enable_reset; // see [R1]
    end
    else if (wr_upper)
    begin
      if (sel_i[0])
      begin
        enable_upper_ff[7:0] <= dat_i[7:0]; // see [R1]
      end
      if (sel_i[1])
      begin
        enable_upper_ff[15:8] <= dat_i[15:8]; // see [R1]
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enable_low_ff <= enable_reset;
    end
    else if (wr_low)
    begin
      if (sel_i[0])
      begin
        enable_low_ff[7:0] <= dat_i[7:0];
      end
      if (sel_i[1])
      begin
        enable_low_ff[15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enable_mid_ff <= enable_reset;
    end
    else if (wr_mid)
    begin
      if (sel_i[0])
      begin
        enable_mid_ff[7:0] <= dat_i[7:0];
      end
      if (sel_i[1])
      begin
        enable_mid_ff[15:8] <= dat_i[15:8];
      end
    end
  end
endmodule

/* dv/irq_upper_properties.sv */
// Port checker for the upper-bank interrupt controller.
// Assumes one clock domain; bound to every controller instance.
`timescale 1ns/100ps
module irq_upper_properties
  import irq_upper_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [7:0] adr_i,
  input wire logic ack_o,
  input wire logic err_o,
  // Processor side
  input wire logic inta,
  input wire logic nmi_req,
  input wire logic set_global_permit,
  input wire logic irq_out,
  input wire logic nmi_out,
  input wire logic [7:0] ack_vector_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_enable_answer: assert property (cyc_i && stb_i && !ack_o && !err_o &&
    adr_i == off_enable_upper |=> ack_o && !err_o) else $error("enable access not acked");
  a_unmapped_err: assert property (cyc_i && stb_i && !ack_o && !err_o &&
    adr_i == 8'hf0 |=> err_o && !ack_o) else $error("unmapped access not refused");
  a_idle_silent: assert property (!cyc_i |=> !ack_o && !err_o)
    else $error("answer without request");
  a_vec_hold: assert property (inta && $past(inta) && $past(inta, 2) |->
    $stable(ack_vector_ff)) else $error("vector moved during acknowledge");
  a_vec_range: assert property (ack_vector_ff >= vector_base &&
    ack_vector_ff <= vector_top) else $error("vector out of range");
  a_entry_blocks: assert property ($rose(inta) && !set_global_permit |=> !irq_out)
    else $error("request kept after entry");
  a_nmi_follows: assert property (nmi_out == nmi_req)
    else $error("nmi not passed on");
  c_ack: cover property ($rose(inta));
  c_err: cover property (err_o);
  c_nmi: cover property (nmi_out);
endmodule
bind irq_upper_ctrl irq_upper_properties chk_u (.*);

/* dv/irq_cpu_model.sv */
// Processor model: runs acknowledge cycles and takes the vector byte.
// Assumes the controller clock and synchronous active-high reset.
`timescale 1ns/100ps
module irq_cpu_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bench control
  input wire logic run,
  input wire logic [2:0] hold,
  // Controller side
  input wire logic irq_out,
  input wire logic [7:0] ack_vector_ff,
  output logic inta,
  output logic [7:0] last_vec_ff,
  output logic [3:0] vec_cnt_ff
);
  logic [3:0] left_ff;
  //////////////////////////////////////////////////////////////////////////////
  // The cycle lasts at least two edges so the captured vector has settled.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      inta <= 1'h0;
      left_ff <= 4'h0;
      last_vec_ff <= 8'h00;
      vec_cnt_ff <= 4'h0;
    end
    else if (!inta)
    begin
      inta <= run && irq_out;
      left_ff <= {1'h0, hold} + 4'h1;
    end
    else if (left_ff != 4'h0)
      left_ff <= left_ff - 4'h1;
    else
    begin
      inta <= 1'h0;
      last_vec_ff <= ack_vector_ff;
      vec_cnt_ff <= vec_cnt_ff + 4'h1;
    end
  end
endmodule

/* dv/test_irq_upper_ctrl.sv */
// Self-checking bench for the upper-bank interrupt controller.
// Assumes the processor model and the bound checker beside it.
`timescale 1ns/100ps
module test_irq_upper_ctrl;
  import irq_upper_pkg::*;
  logic mclk = 0, sys_rst = 1, cyc_i = 0, stb_i = 0, we_i = 0, nmi_req = 0;
  logic handler_exit = 0, set_global_permit = 0, run = 0, inta;
  logic ack_o, err_o, irq_out, nmi_out;
  logic [7:0] adr_i = 8'h00, ack_vector_ff, last_vec_ff;
  logic [3:0] sel_i = 4'h0, vec_cnt_ff;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [47:0] lines = 48'h0;
  logic [15:0] en;
  logic [2:0] hold = 3'h0;
  int error_cnt = 0, n_compared = 0;
  irq_upper_ctrl dut_u (
    .*,
    .timer0_req(lines[47]),
    .dma_req({lines[36], lines[37], lines[38], lines[39]}),
    .bus0_req(lines[35]),
    .audio_req(lines[34]),
    .uart_rx_req(lines[33]),
    .transcoder_req(lines[32]),
    .mid_req(lines[31:16]),
    .uart_tx_req(lines[15]),
    .adc_req(lines[13]),
    .wakeup_req({lines[5], lines[6], lines[7], lines[8], lines[9], lines[10], lines[11], lines[12]}),
    .rng_req(lines[3]),
    .flash_req(lines[1])
  );
  irq_cpu_model cpu_u (.*);
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_vec(logic [47:0] l, logic [15:0] e);
    logic [47:0] m;
    m = l & {e, 32'hffffffff} & ~unconnected_lines;
    exp_vec = vector_base;
    for (int i = 0; i < 48; i++)
      if (m[i])
        exp_vec = vector_base + 8'(i);
  endfunction
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d, logic [15:0] exp, logic e);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= {16'h0, d};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
    if (!w)
      chk("read data", exp, dat_o[15:0]);
    chk("ack and err", {14'h0, !e, e}, {14'h0, ack_o, err_o});
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic wait_vec(logic [3:0] n, logic [7:0] v);
    int t;
    t = 0;
    while (vec_cnt_ff !== n && t < 100)
    begin
      @(posedge mclk);
      t++;
    end
    chk("vector", {8'h0, v}, {8'h0, last_vec_ff});
  endtask
  task automatic pulse(logic is_exit);
    if (is_exit)
    begin
      handler_exit <= 1'h1;
    end
    else
    begin
      set_global_permit <= 1'h1;
    end
    tick(1);
    handler_exit <= 1'h0;
    set_global_permit <= 1'h0;
    tick(1);
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    tick(30000);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h1c820b8d));
    tick(20);
    sys_rst <= 1'h0;
    tick(1);
    bus(1'h0, off_enable_upper, 16'h0, enable_reset, 1'h0);
    bus(1'h0, off_vector, 16'h0, 16'h0010, 1'h0);
    bus(1'h1, 8'hf0, 16'h0, 16'h0, 1'h1);
    for (int k = 0; k < 24; k++)
    begin
      en = (k == 1) ? 16'h7fff : 16'($urandom);
      lines <= (k == 0) ? unconnected_lines : (k == 1) ? 48'h8000_0000_0000 :
        {16'($urandom), 32'($urandom)};
      bus(1'h1, off_enable_upper, en, 16'h0, 1'h0);
      bus(1'h1, off_status_upper, ~en, 16'h0, 1'h0);
      bus(1'h0, off_enable_upper, 16'h0, en, 1'h0);
      bus(1'h0, off_status_upper, 16'h0, lines[47:32] & 16'h80ff, 1'h0);
      bus(1'h0, off_vector, 16'h0, {8'h0, exp_vec(lines, en)}, 1'h0);
      chk("irq", {15'h0, exp_vec(lines, en) != vector_base}, {15'h0, irq_out});
    end
    lines <= 48'h0;
    bus(1'h1, off_enable_upper, 16'hffff, 16'h0, 1'h0);
    hold <= 3'($urandom);
    run <= 1'h1;
    lines <= 48'h04_0000_0000;
    wait_vec(4'h1, 8'h32);
    lines <= 48'h8000_0000_0000;
    bus(1'h1, off_enable_upper, 16'h7fff, 16'h0, 1'h0);
    tick(5);
    chk("blocked", 16'h1, {12'h0, vec_cnt_ff});
    pulse(1'h0);
    tick(5);
    chk("masked", 16'h1, {12'h0, vec_cnt_ff});
    bus(1'h1, off_enable_upper, 16'hffff, 16'h0, 1'h0);
    wait_vec(4'h2, 8'h3f);
    lines <= 48'h80_0000_0000;
    pulse(1'h0);
    wait_vec(4'h3, 8'h37);
    lines <= 48'h0;
    bus(1'h0, off_nest_depth, 16'h0, 16'h3, 1'h0);
    nmi_req <= 1'h1;
    tick(1);
    chk("nmi", 16'h1, {15'h0, nmi_out});
    nmi_req <= 1'h0;
    bus(1'h0, off_nest_depth, 16'h0, 16'h4, 1'h0);
    repeat (4) pulse(1'h1);
    bus(1'h0, off_nest_depth, 16'h0, 16'h0, 1'h0);
    print_verdict();
  end
endmodule
